/* File: include/mrs_pkg.sv */
package mrs_pkg;
  // Reset qualification: least low time on the reset pin, in oscillator cycles
  localparam int unsigned RST_MIN_CYCLES = 16;
  localparam int unsigned CNT_W = 5;
  // Reset vector addresses
  localparam logic [15:0] VEC_LO_ADDR = 16'hfffc;
  localparam logic [15:0] VEC_HI_ADDR = 16'hfffd;
  // Internal clock divide after release (middle-speed)
  localparam int unsigned MID_DIV = 8;
  localparam int unsigned DIV_W = 3;
  // Reset values
  localparam logic [7:0] RV_ZERO = 8'h00;
  localparam logic [7:0] RV_TMR_FF = 8'hff;
  localparam logic [7:0] RV_TMR1 = 8'h01;
  localparam logic [7:0] RV_CSS = 8'h33;
  localparam logic [7:0] RV_I2C_SMST = 8'h20;
  localparam logic [7:0] RV_I2C_SSC = 8'h1a;
  localparam logic [7:0] RV_SIO_STS = 8'h80;
  localparam logic [7:0] RV_UART_CON = 8'he0;
  localparam logic [7:0] RV_WDT_CON = 8'h3f;
  localparam logic [7:0] RV_ADDA_CON = 8'h08;
  localparam logic [7:0] RV_CPU_MODE = 8'h48;
  localparam logic [7:0] RV_FLASH0 = 8'h01;
  localparam logic [7:0] RV_FLASH1 = 8'h40;
  localparam logic [7:0] RV_FLASH2 = 8'h45;
  // Sequencer states
  typedef enum logic [2:0] {
    MRS_RESET = 3'b000,
    MRS_FETCH_LO = 3'b001,
    MRS_WAIT_LO = 3'b010,
    MRS_FETCH_HI = 3'b011,
    MRS_WAIT_HI = 3'b100,
    MRS_RUN = 3'b101
  } mrs_state_t;
endpackage

/* File: include/mrs_rst_if.sv */
`timescale 1ns/1ns
// Qualified reset from the pin filter to the sequencer
interface mrs_rst_if;
  logic qual_rst; // Reset held long enough and still asserted
  logic release_p; // One-cycle pulse on release after qualification
  modport filt(output qual_rst, output release_p);
  modport seq(input qual_rst, input release_p);
endinterface

/* File: verilog/mrs_rst_filter.sv */
`timescale 1ns/1ns
// Synchronises the reset pin and qualifies its low time
module mrs_rst_filter #(
  parameter int unsigned MIN_CYCLES = mrs_pkg::RST_MIN_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_pin_n,
  mrs_rst_if.filt rst
);
  // Counter must be able to hold the least low time
  if (MIN_CYCLES < 1 || MIN_CYCLES >= (1 << mrs_pkg::CNT_W)) begin : g_min_chk
    $error("MIN_CYCLES out of range");
  end

  // Count standing when the last needed low sample arrives
  localparam int unsigned LOW_LAST = MIN_CYCLES - 1;

  logic pin_s1_r; // First synchroniser stage, read only by stage two
  logic pin_s2_r; // Synchronised pin level
  logic [mrs_pkg::CNT_W-1:0] low_cnt_r; // Low cycles seen so far
  logic qual_r; // Low time met
  logic rel_r; // Release pulse

  // Two-flop synchroniser; pin is asynchronous to clk
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= reset_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Count low cycles; a short pulse never qualifies
  always_ff @(posedge clk) begin
    if (!nrst) begin
      low_cnt_r <= '0;
    end else if (pin_s2_r) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != LOW_LAST[mrs_pkg::CNT_W-1:0]) begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  // Qualified reset holds until pin returns high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      qual_r <= 1'b1;
      rel_r <= 1'b0;
    end else begin
      rel_r <= 1'b0;
      if (!pin_s2_r && low_cnt_r == LOW_LAST[mrs_pkg::CNT_W-1:0]) begin
        // The MIN_CYCLES-th low sample itself qualifies
        qual_r <= 1'b1;
      end else if (pin_s2_r && qual_r) begin
        // Release on the high level
        qual_r <= 1'b0;
        rel_r <= 1'b1;
      end
    end
  end

  assign rst.qual_rst = qual_r;
  assign rst.release_p = rel_r;
endmodule

/* File: verilog/mrs_reset_seq.sv */
`timescale 1ns/1ns
module mrs_reset_seq #(
  parameter int unsigned MIN_CYCLES = mrs_pkg::RST_MIN_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_pin_n,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  output logic mem_req,
  output logic [15:0] mem_addr,
  output logic [15:0] pc,
  output logic cpu_run,
  output logic in_reset,
  output logic phi_clk,
  output logic sub_osc_as_port,
  output logic [7:0] port_data [0:6],
  output logic [7:0] port_dir [0:6],
  output logic [7:0] port_pullup [0:6],
  output logic [7:0] tmr_val [0:7],
  output logic [7:0] tmr_mode [0:1],
  output logic [7:0] tmr_css [0:1],
  output logic [7:0] i2c_smst,
  output logic [7:0] i2c_ssc,
  output logic [7:0] i2c_zero [0:6],
  output logic [7:0] sio_sts [0:1],
  output logic [7:0] uart_con [0:1],
  output logic [7:0] sio_con [0:2],
  output logic [7:0] wdt_con,
  output logic [7:0] adda_con,
  output logic [7:0] da_out [0:1],
  output logic [7:0] cpu_mode_reg,
  output logic [7:0] irq_regs [0:5],
  output logic [7:0] flash_ctl [0:2],
  output logic [7:0] pwm_con,
  output logic [7:0] misc_con
);
  // Divider width must cover MID_DIV exactly;
  // any other width would run phi_clk at the wrong rate
  if ((1 << mrs_pkg::DIV_W) != mrs_pkg::MID_DIV) begin : g_div_chk
    $error("divider width mismatch");
  end

  mrs_rst_if rst_c ();

  // Pin qualification lives in the filter
  mrs_rst_filter #(.MIN_CYCLES(MIN_CYCLES)) u_filt (
    .clk(clk),
    .nrst(nrst),
    .reset_pin_n(reset_pin_n),
    .rst(rst_c)
  );

  // Either reset source forces the whole image and parks the fetch
  logic hold; // Registers forced while set
  assign hold = !nrst || rst_c.qual_rst;

  // Divider width kept local so slices read plainly
  localparam int unsigned DIV_W_L = mrs_pkg::DIV_W;
  mrs_pkg::mrs_state_t state_r; // Vector fetch sequencer
  logic [7:0] vec_lo_r; // Captured low vector byte
  logic [DIV_W_L-1:0] div_r; // Internal clock divider

  // Vector fetch: low byte then high byte
  always_ff @(posedge clk) begin
    if (hold) begin
      state_r <= mrs_pkg::MRS_RESET;
      mem_req <= 1'b0;
      mem_addr <= 16'h0000;
      pc <= 16'h0000;
      vec_lo_r <= 8'h00;
      cpu_run <= 1'b0;
    end else begin
      case (state_r)
        // Start right after release
        mrs_pkg::MRS_RESET: begin
          // Only the filter's release pulse starts a fetch
          if (rst_c.release_p) begin
            mem_req <= 1'b1;
            mem_addr <= mrs_pkg::VEC_LO_ADDR;
            state_r <= mrs_pkg::MRS_WAIT_LO;
          end
        end
        mrs_pkg::MRS_WAIT_LO: begin
          mem_req <= 1'b0;
          if (mem_rvalid) begin
            vec_lo_r <= mem_rdata;
            state_r <= mrs_pkg::MRS_FETCH_HI;
          end
        end
        mrs_pkg::MRS_FETCH_HI: begin
          mem_req <= 1'b1;
          mem_addr <= mrs_pkg::VEC_HI_ADDR;
          state_r <= mrs_pkg::MRS_WAIT_HI;
        end
        mrs_pkg::MRS_WAIT_HI: begin
          mem_req <= 1'b0;
          if (mem_rvalid) begin
            pc <= {mem_rdata, vec_lo_r};
            cpu_run <= 1'b1;
            state_r <= mrs_pkg::MRS_RUN;
          end
        end
        // Vector loaded; stay here until the next reset
        mrs_pkg::MRS_RUN: begin
          mem_req <= 1'b0;
        end
        // Unused codes park idle; only a new reset restarts the fetch
        default: begin
          mem_req <= 1'b0;
          state_r <= mrs_pkg::MRS_RESET;
        end
      endcase
    end
  end

  // Middle-speed clock: toggles every half of eight cycles
  // Cleared in reset, so every release starts it in the same phase
  always_ff @(posedge clk) begin
    if (hold) begin
      div_r <= '0;
      phi_clk <= 1'b0;
    end else begin
      div_r <= div_r + 1'b1;
      phi_clk <= div_r[DIV_W_L-1];
    end
  end

  // Reset status and sub-clock pin use; only main osc runs
  // in_reset lags hold by one edge, like every image register
  always_ff @(posedge clk) begin
    in_reset <= hold;
    if (hold) begin
      sub_osc_as_port <= 1'b1;
    end
  end

  // Port image: one slice per port, so each port's flops stand alone.
  // Cleared data and direction leave every pin an input after reset.
  for (genvar gp = 0; gp < 7; gp++) begin : g_port
    always_ff @(posedge clk) begin
      if (hold) begin
        port_data[gp] <= mrs_pkg::RV_ZERO;
        port_dir[gp] <= mrs_pkg::RV_ZERO;
        port_pullup[gp] <= mrs_pkg::RV_ZERO;
      end
      // No else: values hold once the CPU runs
    end
  end

  // Timer image: prescalers and counters preset, modes cleared.
  // Timer Z's two halves share one slot, the last entry of tmr_val.
  always_ff @(posedge clk) begin
    if (hold) begin
      for (int i = 0; i < 8; i++) begin
        // Index 1 is timer 1; the rest prescalers and timers
        tmr_val[i] <= (i == 1) ? mrs_pkg::RV_TMR1 : mrs_pkg::RV_TMR_FF;
      end
      for (int i = 0; i < 2; i++) begin
        tmr_mode[i] <= mrs_pkg::RV_ZERO;
        tmr_css[i] <= mrs_pkg::RV_CSS;
      end
    end
  end

  // Serial image: status bits and UART controls preset, other controls and addresses cleared.
  // Data buffers and baud generators are left out on purpose.
  always_ff @(posedge clk) begin
    if (hold) begin
      i2c_smst <= mrs_pkg::RV_I2C_SMST;
      i2c_ssc <= mrs_pkg::RV_I2C_SSC;
      for (int i = 0; i < 7; i++) begin
        i2c_zero[i] <= mrs_pkg::RV_ZERO;
      end
      for (int i = 0; i < 2; i++) begin
        sio_sts[i] <= mrs_pkg::RV_SIO_STS;
        uart_con[i] <= mrs_pkg::RV_UART_CON;
      end
      for (int i = 0; i < 3; i++) begin
        sio_con[i] <= mrs_pkg::RV_ZERO;
      end
    end
  end

  // System image: watchdog, converter, CPU mode, interrupts, flash.
  // Interrupt registers cleared so nothing is pending or enabled.
  always_ff @(posedge clk) begin
    if (hold) begin
      wdt_con <= mrs_pkg::RV_WDT_CON;
      adda_con <= mrs_pkg::RV_ADDA_CON;
      for (int i = 0; i < 2; i++) begin
        da_out[i] <= mrs_pkg::RV_ZERO;
      end
      cpu_mode_reg <= mrs_pkg::RV_CPU_MODE;
      for (int i = 0; i < 6; i++) begin
        irq_regs[i] <= mrs_pkg::RV_ZERO;
      end
      flash_ctl[0] <= mrs_pkg::RV_FLASH0;
      flash_ctl[1] <= mrs_pkg::RV_FLASH1;
      flash_ctl[2] <= mrs_pkg::RV_FLASH2;
      pwm_con <= mrs_pkg::RV_ZERO;
      misc_con <= mrs_pkg::RV_ZERO;
    end
  end
endmodule

/* File: test/mrs_vec_mem.sv */
`timescale 1ns/1ns
// Vector memory model; answer delay set by the bench
module mrs_vec_mem (
  input wire logic clk,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] lat,
  input wire logic [7:0] vec_lo,
  input wire logic [7:0] vec_hi,
  output logic mem_rvalid,
  output logic [7:0] mem_rdata
);
  initial mem_rvalid = 1'b0;
  initial mem_rdata = 8'h5a;
  // Data toggles while not valid, so stale bytes never look right
  always begin
    @(posedge clk);
    if (mem_req) begin
      repeat (lat) begin
        mem_rdata <= ~mem_rdata;
        @(posedge clk);
      end
      mem_rvalid <= 1'b1;
      mem_rdata <= (mem_addr == 16'hfffd) ? vec_hi : vec_lo;
      @(posedge clk);
      mem_rvalid <= 1'b0;
    end
    mem_rdata <= ~mem_rdata;
  end
endmodule

/* File: test/mrs_props.sv */
`timescale 1ns/1ns
// Port checks on the sequencer
module mrs_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] pc,
  input wire logic cpu_run,
  input wire logic in_reset,
  input wire logic phi_clk,
  input wire logic sub_osc_as_port,
  input wire logic [7:0] tmr_val [0:7],
  input wire logic [7:0] cpu_mode_reg,
  input wire logic [7:0] wdt_con
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  quiet_rst_a: assert property (in_reset |-> !mem_req && !cpu_run)
    else $error("fetch during reset");
  vec_addr_a: assert property (mem_req |-> mem_addr[15:1] == 15'h7ffe)
    else $error("bad vector address");
  first_lo_a: assert property ($fell(in_reset) |-> ##[0:3] mem_req && mem_addr == 16'hfffc)
    else $error("low byte not fetched first");
  req_pulse_a: assert property (mem_req |=> !mem_req)
    else $error("request longer than a cycle");
  pc_load_a: assert property ($rose(cpu_run) |-> $past(mem_rvalid) && pc[15:8] == $past(mem_rdata))
    else $error("pc high byte wrong");
  img_hold_a: assert property (in_reset [*2] |-> cpu_mode_reg == 8'h48 && wdt_con == 8'h3f)
    else $error("mode or watchdog value wrong");
  tmr_init_a: assert property (in_reset [*2] |-> tmr_val[1] == 8'h01 && tmr_val[7] == 8'hff)
    else $error("timer value wrong");
  phi_rst_a: assert property (in_reset [*2] |-> !phi_clk)
    else $error("clock runs in reset");
  phi_div_a: assert property (disable iff (!nrst || in_reset)
    $rose(phi_clk) |=> phi_clk [*3] ##1 !phi_clk [*4])
    else $error("clock not divided by eight");
  sub_port_a: assert property (sub_osc_as_port)
    else $error("sub pins not ports");
endmodule
bind mrs_reset_seq mrs_props u_props (.*);

/* File: test/tb.sv */
`timescale 1ns/1ns
// Reset sequencer bench
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reset_pin_n = 1'b0; // Low from power-on
  logic [3:0] lat = 4'h0; // Vector answer delay
  logic [7:0] vec_lo = 8'h00;
  logic [7:0] vec_hi = 8'h00;
  logic [7:0] mem_rdata;
  logic mem_rvalid, mem_req, cpu_run, in_reset, phi_clk, sub_osc_as_port;
  logic [15:0] mem_addr, pc;
  logic [7:0] port_data [0:6], port_dir [0:6], port_pullup [0:6], i2c_zero [0:6];
  logic [7:0] tmr_val [0:7], tmr_mode [0:1], tmr_css [0:1], sio_sts [0:1], uart_con [0:1];
  logic [7:0] sio_con [0:2], da_out [0:1], irq_regs [0:5], flash_ctl [0:2];
  logic [7:0] i2c_smst, i2c_ssc, wdt_con, adda_con, cpu_mode_reg, pwm_con, misc_con;
  int fail_count = 0;
  int checks_done = 0;
  always #10 clk = ~clk;
  mrs_reset_seq DUT (.*);
  mrs_vec_mem u_mem (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole image compared while reset holds
  task automatic check_image();
    for (int i = 0; i < 7; i++) begin
      chk(port_data[i], 8'h00);
      chk(port_dir[i], 8'h00);
      chk(port_pullup[i], 8'h00);
      chk(i2c_zero[i], 8'h00);
    end
    for (int i = 0; i < 8; i++) chk(tmr_val[i], (i == 1) ? 8'h01 : 8'hff);
    for (int i = 0; i < 2; i++) begin
      chk(tmr_mode[i], 8'h00);
      chk(tmr_css[i], 8'h33);
      chk(sio_sts[i], 8'h80);
      chk(uart_con[i], 8'he0);
      chk(da_out[i], 8'h00);
    end
    for (int i = 0; i < 3; i++) chk(sio_con[i], 8'h00);
    for (int i = 0; i < 6; i++) chk(irq_regs[i], 8'h00);
    chk(flash_ctl[0], 8'h01);
    chk(flash_ctl[1], 8'h40);
    chk(flash_ctl[2], 8'h45);
    chk(i2c_smst, 8'h20);
    chk(i2c_ssc, 8'h1a);
    chk(wdt_con, 8'h3f);
    chk(adda_con, 8'h08);
    chk(cpu_mode_reg, 8'h48);
    chk(pwm_con, 8'h00);
    chk(misc_con, 8'h00);
  endtask
  // Pin high, then the vector must land in pc
  task automatic fetch(input logic [3:0] l, input logic [7:0] lo, input logic [7:0] hi);
    int n;
    @(negedge clk);
    lat = l;
    vec_lo = lo;
    vec_hi = hi;
    reset_pin_n = 1'b1;
    n = 0;
    while (cpu_run !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, cpu_run}, 8'h01);
    chk(pc[15:8], hi);
    chk(pc[7:0], lo);
  endtask
  // Pin low for len cycles; left low, the caller raises it again
  task automatic pin_low(input int len);
    @(negedge clk);
    reset_pin_n = 1'b0;
    repeat (len) @(negedge clk);
  endtask
  // Exactly the least low time must still reset
  task automatic short_min();
    logic seen;
    pin_low(16);
    reset_pin_n = 1'b1;
    seen = 1'b0;
    repeat (8) begin
      @(negedge clk);
      seen = seen | in_reset;
    end
    chk({7'h00, seen}, 8'h01);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (20) @(negedge clk);
    check_image();
    fetch(4'h0, 8'h34, 8'h12);
    pin_low(15);
    reset_pin_n = 1'b1;
    repeat (24) @(negedge clk);
    chk({7'h00, in_reset}, 8'h00);
    chk({7'h00, cpu_run}, 8'h01);
    short_min();
    fetch(4'h0, 8'h34, 8'h12);
    pin_low(20);
    chk({7'h00, in_reset}, 8'h01);
    check_image();
    fetch(4'h3, 8'hcd, 8'hab);
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, in_reset}, 8'h01);
    chk({7'h00, cpu_run}, 8'h00);
    nrst = 1'b1;
    fetch(4'h1, 8'h00, 8'hff);
    end_sim();
  end
  // Hang guard, far beyond the fewer than two hundred cycles used
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule
